/* File: lcd_cmd_pkg.sv */
package lcd_cmd_pkg;

    // ****************************************************************
    // Command codes and masks
    // ****************************************************************
    localparam logic [7:0] CMD_DISP_ONOFF    = 8'hae;
    localparam logic [7:0] CMD_REVERSE       = 8'ha6;
    localparam logic [7:0] CMD_ALL_LIT       = 8'ha4;
    localparam logic [7:0] CMD_COM_SCAN      = 8'hc4;
    localparam logic [7:0] CMD_START_LINE    = 8'h8a;
    localparam logic [7:0] CMD_INPUT_DIR     = 8'h84;
    localparam logic [7:0] CMD_SEG_REMAP     = 8'ha0;
    localparam logic [7:0] CMD_SOFT_RESET    = 8'he2;
    localparam logic [7:0] MASK_D0           = 8'hfe;
    localparam logic [7:0] MASK_NIBBLE       = 8'hf0;
    localparam logic [7:0] CMD_PAGE          = 8'hb0;
    localparam logic [7:0] CMD_COL_HIGH      = 8'h10;
    localparam logic [7:0] CMD_COL_LOW       = 8'h00;
    localparam logic [7:0] CMD_INVERSION     = 8'h30;

    // ****************************************************************
    // Geometry and reset values
    // ****************************************************************
    localparam int         PAGES             = 9;
    localparam int         COLUMNS           = 168;
    localparam int         LINES             = 64;
    localparam logic [3:0] PAGE_LAST         = 4'h8;
    localparam logic [7:0] COL_LAST          = 8'ha7;
    localparam logic [5:0] START_LINE_RESET  = 6'h00;
    localparam logic [3:0] INVERSION_RESET   = 4'hc;
    localparam int         LINE_STEP         = 4;

    typedef enum logic [1:0] {XFER_NONE, XFER_CMD, XFER_DATA_WR,
                              XFER_DATA_RD} xfer_e;

endpackage

/* File: lcd_bus_if.sv */
`timescale 1ns/100ps
interface lcd_bus_if;
    logic       valid;
    logic       is_data;
    logic       is_read;
    logic [7:0] value;

    modport source (output valid, output is_data, output is_read,
                    output value);
    modport sink   (input valid, input is_data, input is_read,
                    input value);
endinterface

/* File: lcd_host_port.sv */
`timescale 1ns/100ps
module lcd_host_port (
    input  wire logic   clk_sys,
    input  wire logic   rstn,
    input  wire logic   mode_68,
    input  wire logic   serial_sel,
    input  wire logic   cmd_data_select,
    input  wire logic   rd_e,
    input  wire logic   wr_rw,
    input  wire logic   cs_n,
    input  wire logic   sclk,
    input  wire logic   sdata,
    input  wire logic [7:0] bus_in,
    lcd_bus_if.source   xfer
);
    logic [5:0] s1;
    logic [5:0] s2;
    logic [7:0] bus_q1;
    logic [7:0] bus_q2;
    logic       strobe_d;
    logic       sclk_d;
    logic [7:0] shift;
    logic [2:0] bit_count;
    logic       strobe_on;
    logic       strobe_end;
    logic       sclk_rise;
    logic       par_read;
    logic       read_q;
    logic       valid;
    logic       is_data;
    logic       is_read;
    logic [7:0] value;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        s1     <= {cmd_data_select, rd_e, wr_rw, cs_n, sclk, sdata};
        s2     <= s1;
        bus_q1 <= bus_in;
        bus_q2 <= bus_q1;
    end

    // The transfer is taken at the end of the strobe pulse, when the host
    // data is sure to be settled.
    assign strobe_on  = !s2[2] && (mode_68 ? s2[4] : (!s2[4] || !s2[3]));
    assign strobe_end = strobe_d && !strobe_on;
    assign par_read   = mode_68 ? s2[3] : !s2[4];
    assign sclk_rise  = !s2[2] && s2[1] && !sclk_d;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            strobe_d  <= 1'b0;
            read_q    <= 1'b0;
            sclk_d    <= 1'b0;
            shift     <= 8'h00;
            bit_count <= 3'h0;
            valid     <= 1'b0;
            is_data   <= 1'b0;
            is_read   <= 1'b0;
            value     <= 8'h00;
        end else begin
            strobe_d <= strobe_on;
            // The 80-style read strobe is already high at the strobe end,
            // so the direction is held from inside the pulse.
            if (strobe_on)
                read_q <= par_read;
            sclk_d   <= s2[1];
            valid    <= 1'b0;
            if (serial_sel) begin
                if (s2[2]) begin
                    bit_count <= 3'h0;
                end else if (sclk_rise) begin
                    shift     <= {shift[6:0], s2[0]};
                    bit_count <= bit_count + 3'h1;
                    if (bit_count == 3'h7) begin
                        valid   <= 1'b1;
                        is_data <= s2[5];
                        is_read <= 1'b0;
                        value   <= {shift[6:0], s2[0]};
                    end
                end
            end else if (strobe_end) begin
                valid   <= 1'b1;
                is_data <= s2[5];
                is_read <= read_q;
                value   <= bus_q2;
            end
        end
    end

    assign xfer.valid   = valid;
    assign xfer.is_data = is_data;
    assign xfer.is_read = is_read;
    assign xfer.value   = value;
endmodule

/* File: lcd_cmd_decoder.sv */
`timescale 1ns/100ps
module lcd_cmd_decoder #(
    parameter int PAGES   = lcd_cmd_pkg::PAGES,
    parameter int COLUMNS = lcd_cmd_pkg::COLUMNS
) (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       mode_68,
    input  wire logic       serial_sel,
    input  wire logic       cmd_data_select,
    input  wire logic       rd_e,
    input  wire logic       wr_rw,
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       sdata,
    input  wire logic [7:0] bus_in,
    input  wire logic       line_tick,
    input  wire logic       frame_start,
    input  wire logic [7:0] scan_column,
    output logic      [7:0] bus_out,
    output logic      [7:0] bus_oe_n,
    output logic            display_on,
    output logic            reverse_on,
    output logic            all_lit,
    output logic            com_reverse,
    output logic            seg_remap,
    output logic            page_dir,
    output logic            modify_mode,
    output logic      [5:0] start_line_bits,
    output logic      [3:0] page_bits,
    output logic      [7:0] column_bits,
    output logic      [3:0] inversion_count_bits,
    output logic      [5:0] scan_line,
    output logic            drive_polarity,
    output logic            mid_bias_level,
    output logic            pixel_on
);
    lcd_bus_if xfer ();

    logic [7:0] ram [PAGES*COLUMNS];
    logic       param_pending;
    logic       dummy_pending;
    logic [7:0] read_latch;
    logic [5:0] line_count;
    logic [5:0] lines_done;
    logic [7:0] ram_pixel_byte;
    logic       read_drive;
    logic [3:0] pin_q1;
    logic [3:0] pin_q2;

    wire logic [7:0] v        = xfer.value;
    wire logic       take_cmd = xfer.valid && !xfer.is_data;
    wire logic       take_wr  = xfer.valid && xfer.is_data && !xfer.is_read;
    wire logic       take_rd  = xfer.valid && xfer.is_data && xfer.is_read
                                && !serial_sel;
    wire logic       is_param = take_wr && param_pending;
    wire logic       data_wr  = take_wr && !param_pending;
    wire logic       access   = data_wr || take_rd;
    wire logic       hit_d0   = take_cmd && !param_pending;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic match(input logic [7:0] b,
                                   input logic [7:0] code,
                                   input logic [7:0] mask);
        return (b & mask) == code;
    endfunction

    function automatic int addr_of(input logic [3:0] pg,
                                   input logic [7:0] col);
        return int'(pg) * COLUMNS + int'(col);
    endfunction

    wire logic c_disp  = hit_d0 && match(v, lcd_cmd_pkg::CMD_DISP_ONOFF,
                                         lcd_cmd_pkg::MASK_D0);
    wire logic c_rev   = hit_d0 && match(v, lcd_cmd_pkg::CMD_REVERSE,
                                         lcd_cmd_pkg::MASK_D0);
    wire logic c_all   = hit_d0 && match(v, lcd_cmd_pkg::CMD_ALL_LIT,
                                         lcd_cmd_pkg::MASK_D0);
    wire logic c_com   = hit_d0 && match(v, lcd_cmd_pkg::CMD_COM_SCAN,
                                         lcd_cmd_pkg::MASK_D0);
    wire logic c_dir   = hit_d0 && match(v, lcd_cmd_pkg::CMD_INPUT_DIR,
                                         lcd_cmd_pkg::MASK_D0);
    wire logic c_seg   = hit_d0 && match(v, lcd_cmd_pkg::CMD_SEG_REMAP,
                                         lcd_cmd_pkg::MASK_D0);
    wire logic c_start = hit_d0 && (v == lcd_cmd_pkg::CMD_START_LINE);
    wire logic c_sreset = hit_d0 && (v == lcd_cmd_pkg::CMD_SOFT_RESET);
    wire logic c_page  = hit_d0 && match(v, lcd_cmd_pkg::CMD_PAGE,
                                         lcd_cmd_pkg::MASK_NIBBLE);
    wire logic c_colh  = hit_d0 && match(v, lcd_cmd_pkg::CMD_COL_HIGH,
                                         lcd_cmd_pkg::MASK_NIBBLE);
    wire logic c_coll  = hit_d0 && match(v, lcd_cmd_pkg::CMD_COL_LOW,
                                         lcd_cmd_pkg::MASK_NIBBLE);
    wire logic c_inv   = hit_d0 && match(v, lcd_cmd_pkg::CMD_INVERSION,
                                         lcd_cmd_pkg::MASK_NIBBLE);
    wire logic addr_load = c_page || c_colh || c_coll;

    wire logic [7:0] next_column = (column_bits == lcd_cmd_pkg::COL_LAST)
                                   ? 8'h00 : column_bits + 8'h01;
    wire logic [3:0] next_page   = (page_bits == lcd_cmd_pkg::PAGE_LAST)
                                   ? 4'h0 : page_bits + 4'h1;

    // ****************************************************************
    // Host port
    // ****************************************************************
    lcd_host_port u_port (
        .clk_sys         (clk_sys),
        .rstn            (rstn),
        .mode_68         (mode_68),
        .serial_sel      (serial_sel),
        .cmd_data_select (cmd_data_select),
        .rd_e            (rd_e),
        .wr_rw           (wr_rw),
        .cs_n            (cs_n),
        .sclk            (sclk),
        .sdata           (sdata),
        .bus_in          (bus_in),
        .xfer            (xfer)
    );

    // ****************************************************************
    // Command state
    // ****************************************************************
    // All decoding happens on clk_sys; the host sclk is only sampled, never used as a clock.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            display_on           <= 1'b0;
            reverse_on           <= 1'b0;
            all_lit              <= 1'b0;
            com_reverse          <= 1'b0;
            seg_remap            <= 1'b0;
            page_dir             <= 1'b0;
            modify_mode          <= 1'b0;
            start_line_bits      <= lcd_cmd_pkg::START_LINE_RESET;
            page_bits            <= 4'h0;
            column_bits          <= 8'h00;
            inversion_count_bits <= lcd_cmd_pkg::INVERSION_RESET;
            param_pending        <= 1'b0;
        end else begin
            if (c_disp)  display_on  <= v[0];
            if (c_rev)   reverse_on  <= v[0];
            if (c_all)   all_lit     <= v[0];
            if (c_com)   com_reverse <= v[0];
            if (c_seg)   seg_remap   <= v[0];
            if (c_dir)   page_dir    <= v[0];
            if (c_inv)   inversion_count_bits <= v[3:0];
            if (c_page && v[3:0] <= lcd_cmd_pkg::PAGE_LAST)
                page_bits <= v[3:0];
            if (c_colh)  column_bits[7:4] <= v[3:0];
            if (c_coll)  column_bits[3:0] <= v[3:0];
            if (c_start) param_pending <= 1'b1;
            if (is_param) begin
                start_line_bits <= v[5:0];
                param_pending   <= 1'b0;
            end
            if (c_sreset) begin
                column_bits <= 8'h00;
                page_dir    <= 1'b0;
                modify_mode <= 1'b0;
            end
            if (access) begin
                if (page_dir)
                    page_bits <= next_page;
                else
                    column_bits <= next_column;
            end
        end
    end
    // Unmatched command codes hit no decode term and so change nothing.

    // ****************************************************************
    // Display RAM access
    // ****************************************************************
    // The read pipeline returns the byte fetched by the previous read, so
    // the first read after an address load returns 8'h00 as a dummy byte.
    always_ff @(posedge clk_sys) begin
        if (data_wr)
            ram[addr_of(page_bits, column_bits)] <= v;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            read_latch    <= 8'h00;
            bus_out       <= 8'h00;
            dummy_pending <= 1'b1;
        end else begin
            if (addr_load)
                dummy_pending <= 1'b1;
            if (take_rd) begin
                bus_out       <= dummy_pending ? 8'h00 : read_latch;
                read_latch    <= ram[addr_of(page_bits, column_bits)];
                dummy_pending <= 1'b0;
            end
        end
    end

    // The output enable follows synchronised pins, so it turns on two
    // clocks after the read strobe (68-style: R/W high with chip select low and A0 high, E ignored) and off two clocks after it ends.
    always_ff @(posedge clk_sys) begin
        pin_q1 <= {cs_n, cmd_data_select, wr_rw, rd_e};
        pin_q2 <= pin_q1;
    end

    assign read_drive = !serial_sel && !pin_q2[3] && pin_q2[2]
                        && (mode_68 ? pin_q2[1] : !pin_q2[0]);
    assign bus_oe_n   = read_drive ? 8'h00 : 8'hff;

    // ****************************************************************
    // Scan and drive
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            line_count     <= 6'h00;
            lines_done     <= 6'h00;
            drive_polarity <= 1'b0;
        end else if (frame_start) begin
            line_count <= 6'h00;
            lines_done <= 6'h00;
        end else if (line_tick) begin
            line_count <= line_count + 6'h01;
            if (lines_done == {inversion_count_bits, 2'b11}) begin
                lines_done     <= 6'h00;
                drive_polarity <= !drive_polarity;
            end else begin
                lines_done <= lines_done + 6'h01;
            end
        end
    end

    wire logic [5:0] scan_row  = com_reverse ? ~line_count : line_count;
    wire logic [5:0] ram_line  = start_line_bits + scan_row;
    wire logic [7:0] ram_col   = seg_remap ? (lcd_cmd_pkg::COL_LAST - scan_column)
                                           : scan_column;
    assign scan_line      = ram_line;
    assign ram_pixel_byte = ram[addr_of({1'b0, ram_line[5:3]}, ram_col)];
    assign mid_bias_level = !display_on;
    assign pixel_on = display_on && (all_lit
                      || (ram_pixel_byte[ram_line[2:0]] ^ reverse_on));
endmodule

/* File: lcd_cmd_chk.sv */
`timescale 1ns/100ps
module lcd_cmd_chk #(
    parameter int PAGES   = lcd_cmd_pkg::PAGES,
    parameter int COLUMNS = lcd_cmd_pkg::COLUMNS
) (
    input wire logic       clk_sys,
    input wire logic       rstn,
    input wire logic       cs_n,
    input wire logic       serial_sel,
    input wire logic       line_tick,
    input wire logic       frame_start,
    input wire logic [7:0] bus_oe_n,
    input wire logic       display_on,
    input wire logic       reverse_on,
    input wire logic       all_lit,
    input wire logic [5:0] start_line_bits,
    input wire logic [3:0] page_bits,
    input wire logic [7:0] column_bits,
    input wire logic [3:0] inversion_count_bits,
    input wire logic       drive_polarity,
    input wire logic       mid_bias_level,
    input wire logic       pixel_on
);
    // ****************************************************************
    // Output relations
    // ****************************************************************
    a_bias_when_off: assert property (@(posedge clk_sys)
        disable iff (!rstn) mid_bias_level == !display_on)
        else $error("bias level does not follow display off");
    a_reset_defaults: assert property (@(posedge clk_sys)
        !rstn |=> start_line_bits == 6'h00 && inversion_count_bits == 4'hc
            && !display_on && page_bits == 4'h0 && column_bits == 8'h00)
        else $error("reset values wrong");
    // Eight idle cycles outlast the strobe synchroniser and decode delay.
    a_quiet_hold: assert property (@(posedge clk_sys)
        disable iff (!rstn) cs_n [*8] |-> $stable(display_on)
            && $stable(page_bits) && $stable(column_bits)
            && $stable(start_line_bits))
        else $error("setting changed without a transfer");
    a_column_range: assert property (@(posedge clk_sys)
        disable iff (!rstn) column_bits < COLUMNS)
        else $error("column beyond last");
    a_page_range: assert property (@(posedge clk_sys)
        disable iff (!rstn) page_bits < PAGES)
        else $error("page beyond last");
    a_serial_noread: assert property (@(posedge clk_sys)
        disable iff (!rstn) serial_sel |-> bus_oe_n == 8'hff)
        else $error("bus driven in serial mode");
    a_oe_whole: assert property (@(posedge clk_sys)
        disable iff (!rstn) bus_oe_n == 8'h00 || bus_oe_n == 8'hff)
        else $error("partial bus drive");
    a_all_lit: assert property (@(posedge clk_sys)
        disable iff (!rstn) display_on && all_lit && !reverse_on |-> pixel_on)
        else $error("pixel dark while all lit");
    a_polarity_tick: assert property (@(posedge clk_sys)
        disable iff (!rstn)
        $changed(drive_polarity) |-> $past(line_tick) || $past(frame_start))
        else $error("polarity flipped off a line boundary");
endmodule

bind lcd_cmd_decoder lcd_cmd_chk #(.PAGES(PAGES), .COLUMNS(COLUMNS))
    lcd_cmd_chk_i (.clk_sys, .rstn, .cs_n, .serial_sel, .line_tick,
    .frame_start, .bus_oe_n, .display_on, .reverse_on, .all_lit,
    .start_line_bits, .page_bits, .column_bits, .inversion_count_bits,
    .drive_polarity, .mid_bias_level, .pixel_on);

/* File: lcd_host_model.sv */
`timescale 1ns/100ps
module lcd_host_model (
    input  wire logic       clk_sys,
    input  wire logic       mode_68,
    output logic            cmd_data_select,
    output logic            rd_e,
    output logic            wr_rw,
    output logic            cs_n,
    output logic            sclk,
    output logic            sdata,
    output logic      [7:0] bus_in
);
    // ****************************************************************
    // Host bus idle and transfers
    // ****************************************************************
    initial begin
        {cs_n, wr_rw, rd_e, sclk, sdata, cmd_data_select} = 6'h38;
        bus_in = 8'h5a;
    end
    // Released lines flip so a stale byte can never pass for a fresh one.
    task automatic idle();
        cs_n = 1'b1;
        wr_rw = 1'b1;
        rd_e = !mode_68;
        sclk = 1'b0;
        sdata = !sdata;
        bus_in = ~bus_in;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic put(input logic rd, input logic a0, input logic [7:0] d);
        tick(1);
        cs_n = 1'b0;
        cmd_data_select = a0;
        bus_in = rd ? ~d : d;
        wr_rw = mode_68 ? rd : 1'b1;
        tick(2);
        if (mode_68) rd_e = 1'b1;
        else if (rd) rd_e = 1'b0;
        else wr_rw = 1'b0;
        tick(4);
        rd_e = !mode_68;
        if (!mode_68) wr_rw = 1'b1;
        tick(4);
        idle();
        tick(4);
    endtask
    task automatic ser(input logic a0, input logic [7:0] d);
        tick(1);
        cs_n = 1'b0;
        cmd_data_select = a0;
        for (int i = 7; i >= 0; i--) begin
            sdata = d[i];
            tick(3);
            sclk = 1'b1;
            tick(3);
            sclk = 1'b0;
        end
        tick(3);
        idle();
        tick(8);
    endtask
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
    logic       clk_sys, rstn, mode_68, serial_sel, line_tick, frame_start;
    logic       cmd_data_select, rd_e, wr_rw, cs_n, sclk, sdata;
    logic       display_on, reverse_on, all_lit, com_reverse, seg_remap;
    logic       page_dir, modify_mode, drive_polarity, mid_bias_level;
    logic       pixel_on;
    logic [7:0] bus_in, bus_out, bus_oe_n, column_bits, scan_column, exp;
    logic [5:0] start_line_bits, scan_line;
    logic [3:0] page_bits, inversion_count_bits;
    int         n_mismatch, check_count, tick_cnt;
    logic [7:0] code [6] = '{8'hae, 8'ha4, 8'ha6, 8'hc4, 8'ha0, 8'h84};
    logic [7:0] mask [6] = '{8'h20, 8'h08, 8'h10, 8'h04, 8'h02, 8'h01};
    wire  [7:0] flags = {2'b00, display_on, reverse_on, all_lit,
                         com_reverse, seg_remap, page_dir};

    lcd_cmd_decoder lcd_cmd_decoder_i (.clk_sys, .rstn, .mode_68,
        .serial_sel, .cmd_data_select, .rd_e, .wr_rw, .cs_n, .sclk, .sdata,
        .bus_in, .line_tick, .frame_start, .scan_column, .bus_out, .bus_oe_n,
        .display_on, .reverse_on, .all_lit, .com_reverse, .seg_remap,
        .page_dir, .modify_mode, .start_line_bits, .page_bits, .column_bits,
        .inversion_count_bits, .scan_line, .drive_polarity, .mid_bias_level,
        .pixel_on);
    lcd_host_model lcd_host_model_i (.clk_sys, .mode_68, .cmd_data_select,
        .rd_e, .wr_rw, .cs_n, .sclk, .sdata, .bus_in);

    // ****************************************************************
    // Clock, scan timing and helpers
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        #1;
        tick_cnt = tick_cnt + 1;
        line_tick = (tick_cnt % 16 == 0);
        frame_start = (tick_cnt % 1040 == 0);
        scan_column = 8'(tick_cnt % 168);
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] want);
        check_count++;
        if (got !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        lcd_host_model_i.put(1'b0, 1'b0, c);
    endtask
    task automatic dat(input logic [7:0] d);
        lcd_host_model_i.put(1'b0, 1'b1, d);
    endtask
    task automatic rdd();
        lcd_host_model_i.put(1'b1, 1'b1, 8'h00);
    endtask
    // Bus mode is only changed under reset, so no false strobe edge appears.
    task automatic do_reset(input logic m68, input logic ser);
        @(posedge clk_sys);
        #1;
        rstn = 1'b0;
        mode_68 = m68;
        serial_sel = ser;
        lcd_host_model_i.idle();
        repeat (16) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #200us;
        n_mismatch++;
        $display("mismatch at %0t: run did not complete", $time);
        finish_test();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        {rstn, mode_68, serial_sel} = 3'h0;
        do_reset(1'b0, 1'b0);
        cmp(flags, 8'h00);
        cmp({2'b00, start_line_bits}, 8'h00);
        cmp({4'h0, inversion_count_bits}, 8'h0c);
        cmp({4'h0, page_bits}, 8'h00);
        cmp(column_bits, 8'h00);
        cmp({7'h00, mid_bias_level}, 8'h01);
        exp = 8'h00;
        for (int i = 0; i < 6; i++) begin
            cmd(code[i] | 8'h01);
            exp = exp | mask[i];
            cmp(flags, exp);
        end
        for (int i = 0; i < 6; i++) begin
            cmd(code[i]);
            exp = exp & ~mask[i];
            cmp(flags, exp);
        end
        cmd(8'h8a);
        dat(8'hff);
        cmp({2'b00, start_line_bits}, 8'h3f);
        cmd(8'h8a);
        dat(8'hc5);
        cmp({2'b00, start_line_bits}, 8'h05);
        cmd(8'hfc);
        cmp({2'b00, start_line_bits}, 8'h05);
        cmp(flags, 8'h00);
        cmd(8'h33);
        cmp({4'h0, inversion_count_bits}, 8'h03);
        cmd(8'h3e);
        cmp({4'h0, inversion_count_bits}, 8'h0e);
        cmd(8'hb8);
        cmd(8'hb9);
        cmp({4'h0, page_bits}, 8'h08);
        cmd(8'hb3);
        cmp({4'h0, page_bits}, 8'h03);
        cmd(8'h1a);
        cmd(8'h06);
        cmp(column_bits, 8'ha6);
        dat(8'h11);
        cmp(column_bits, 8'ha7);
        dat(8'h22);
        cmp(column_bits, 8'h00);
        cmd(8'h1a);
        cmd(8'h06);
        fork
            rdd();
            begin
                repeat (6) @(posedge clk_sys);
                #2;
                cmp(bus_oe_n, 8'h00);
            end
        join
        cmp(bus_out, 8'h00);
        cmp(column_bits, 8'ha7);
        rdd();
        cmp(bus_out, 8'h11);
        rdd();
        cmp(bus_out, 8'h22);
        cmp(column_bits, 8'h01);
        cmd(8'h85);
        cmd(8'ha7);
        cmd(8'he2);
        cmp(column_bits, 8'h00);
        cmp(flags, 8'h10);
        cmp({4'h0, page_bits}, 8'h03);
        do_reset(1'b1, 1'b0);
        cmd(8'h85);
        cmd(8'hb0);
        cmd(8'h10);
        cmd(8'h00);
        dat(8'h5a);
        cmp({4'h0, page_bits}, 8'h01);
        cmp(column_bits, 8'h00);
        cmd(8'hb0);
        rdd();
        rdd();
        cmp(bus_out, 8'h5a);
        cmp({4'h0, page_bits}, 8'h02);
        do_reset(1'b0, 1'b1);
        lcd_host_model_i.ser(1'b0, 8'haf);
        cmp(flags, 8'h20);
        lcd_host_model_i.ser(1'b0, 8'h12);
        lcd_host_model_i.ser(1'b0, 8'h05);
        cmp(column_bits, 8'h25);
        fork
            rdd();
            begin
                repeat (6) @(posedge clk_sys);
                #2;
                cmp(bus_oe_n, 8'hff);
            end
        join
        cmp(column_bits, 8'h25);
        cmp(bus_oe_n, 8'hff);
        finish_test();
    end
endmodule
